// >>> src/hbp_div.sv
// Restoring serial divider, one quotient bit per clock
`timescale 1ns/100ps
module hbp_div (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     start,
    input  wire logic [hbp_pkg::NUM_W-1:0] num,
    input  wire logic [hbp_pkg::DW-1:0]   den,
    output logic                          busy,
    output logic                          done,
    output logic [hbp_pkg::NUM_W-1:0]     quot
);
    import hbp_pkg::*;
    logic [NUM_W-1:0] quot_q, quot_d;
    logic [DW:0]      rem_q, rem_d;
    logic [DW-1:0]    den_q, den_d;
    logic [5:0]       cnt_q, cnt_d;
    logic             busy_q, busy_d, done_q, done_d;
    logic [DW:0]      trial;

    always_comb begin
        quot_d = quot_q;
        rem_d  = rem_q;
        den_d  = den_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        trial  = {rem_q[DW-1:0], quot_q[NUM_W-1]};
        if (start && !busy_q) begin
            quot_d = num;
            rem_d  = '0;
            den_d  = den;
            cnt_d  = 6'(NUM_W);
            busy_d = 1'b1;
        end else if (busy_q) begin
            // Shift dividend bits out as quotient bits shift in
            if (trial >= {1'b0, den_q}) begin
                rem_d  = trial - {1'b0, den_q};
                quot_d = {quot_q[NUM_W-2:0], 1'b1};
            end else begin
                rem_d  = trial;
                quot_d = {quot_q[NUM_W-2:0], 1'b0};
            end
            cnt_d = cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quot_q <= '0;
            rem_q  <= '0;
            den_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            quot_q <= quot_d;
            rem_q  <= rem_d;
            den_q  <= den_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign quot = quot_q;
endmodule // hbp_div

// >>> src/hbp_duty_mapper.sv
// H-bridge PWM duty mapper with AHB-Lite register slave
// Contract
// R1 - All four drives share one counter, one period.
// R2 - High and low switch of a side never conduct together.
// R3 - Dead interval on both edges between high and low conduction.
// R4 - Every duty value counts the high time of its output.
// R5 - Low switches conduct while their drive is high.
// R6 - High switches conduct while drive low; conduction is one minus duty.
// R7 - Side A low duty is side A high duty minus twice dead time.
// R8 - Side B high is one minus A high; B low subtracts twice dead.
// R9 - Current from A to B is positive; controller output rises.
// R10 - Side A high on-time rises monotonically with controller output.
// R11 - Controller output clamped to programmable upper and lower limits.
// R12 - Lower limit maps to minimum on-time, upper to maximum.
// R13 - On-time is linear interpolation between the limits.
// R14 - After on-time, derive all four duties and load them together.
// R15 - Duties kept inside a bounded sub-range of the period.
// R16 - Duties and dead time are counts; update only at period boundary.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
module hbp_duty_mapper (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic                      side_a_high_drive,
    output logic                      side_a_low_drive,
    output logic                      side_b_high_drive,
    output logic                      side_b_low_drive
);
    import hbp_pkg::*;

    function automatic logic [DW-1:0] sat_sub(input logic [DW-1:0] a, input logic [DW-1:0] b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction

    // ****************************************************
    // Reset release
    // ****************************************************
    logic rst_m_q, rst_s_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // ****************************************************
    // AHB-Lite slave: writes zero wait, reads one wait
    // ****************************************************
    logic       wr_ph_q, wr_ph_d, rd_wait_q, rd_wait_d;
    logic [7:0] dp_addr_q, dp_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic       addr_ok;
    assign addr_ok = hsel && hready && (htrans == HTRANS_NSEQ);

    logic          en_q, en_d, go_q, go_d;
    logic [DW-1:0] ctl_q, ctl_d, emin_q, emin_d, emax_q, emax_d;
    logic [DW-1:0] tmin_q, tmin_d, tmax_q, tmax_d, per_q, per_d, dead_q, dead_d;
    logic          chi_q, chi_d, clo_q, clo_d;
    hbp_state_e    st_q, st_d;
    logic          pend_q, pend_d;
    logic [DW-1:0] on_q, on_d, dah_p_q, dah_p_d, dal_p_q, dal_p_d;
    logic [DW-1:0] dbh_p_q, dbh_p_d, dbl_p_q, dbl_p_d, per_p_q, per_p_d, dead_p_q, dead_p_d;
    logic [DW-1:0] dah_q, dah_d, dal_q, dal_d, dbl_q, dbl_d;
    logic [DW-1:0] per_a_q, per_a_d, dead_a_q, dead_a_d, cnt_q, cnt_d;
    logic          wrap;
    logic          wr_ctl;
    assign wr_ctl = wr_ph_q && (dp_addr_q == OFF_CTL_OUT);

    always_comb begin
        wr_ph_d   = addr_ok && hwrite;
        rd_wait_d = addr_ok && !hwrite;
        dp_addr_d = addr_ok ? haddr[7:0] : dp_addr_q;
        hrdata_d  = hrdata_q;
        if (rd_wait_q) begin
            unique case (dp_addr_q)
                OFF_CTRL:    hrdata_d = {31'h0, en_q};
                OFF_CTL_OUT: hrdata_d = {16'h0, ctl_q};
                OFF_E_MIN:   hrdata_d = {16'h0, emin_q};
                OFF_E_MAX:   hrdata_d = {16'h0, emax_q};
                OFF_T_MIN:   hrdata_d = {16'h0, tmin_q};
                OFF_T_MAX:   hrdata_d = {16'h0, tmax_q};
                OFF_PERIOD:  hrdata_d = {16'h0, per_q};
                OFF_DEAD:    hrdata_d = {16'h0, dead_q};
                OFF_STATUS:  hrdata_d = {28'h0, clo_q, chi_q, pend_q, st_q != S_IDLE};
                OFF_DUTY_AH: hrdata_d = {16'h0, dah_q};
                OFF_ON_TIME: hrdata_d = {16'h0, on_q};
                default:     hrdata_d = 32'h0;
            endcase
        end
        en_d   = en_q;
        ctl_d  = ctl_q;
        emin_d = emin_q;
        emax_d = emax_q;
        tmin_d = tmin_q;
        tmax_d = tmax_q;
        per_d  = per_q;
        dead_d = dead_q;
        if (wr_ph_q) begin
            unique case (dp_addr_q)
                OFF_CTRL:    en_d   = hwdata[CTRL_EN_BIT];
                OFF_CTL_OUT: ctl_d  = hwdata[DW-1:0];
                OFF_E_MIN:   emin_d = hwdata[DW-1:0];
                OFF_E_MAX:   emax_d = hwdata[DW-1:0];
                OFF_T_MIN:   tmin_d = hwdata[DW-1:0];
                OFF_T_MAX:   tmax_d = hwdata[DW-1:0];
                OFF_PERIOD:  per_d  = hwdata[DW-1:0];
                OFF_DEAD:    dead_d = hwdata[DW-1:0];
                default:     en_d   = en_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            wr_ph_q   <= 1'b0;
            rd_wait_q <= 1'b0;
            dp_addr_q <= '0;
            hrdata_q  <= '0;
            en_q      <= 1'b0;
            ctl_q     <= RST_CTL_OUT;
            emin_q    <= RST_E_MIN;
            emax_q    <= RST_E_MAX;
            tmin_q    <= RST_T_MIN;
            tmax_q    <= RST_T_MAX;
            per_q     <= RST_PERIOD;
            dead_q    <= RST_DEAD;
        end else begin
            wr_ph_q   <= wr_ph_d;
            rd_wait_q <= rd_wait_d;
            dp_addr_q <= dp_addr_d;
            hrdata_q  <= hrdata_d;
            en_q      <= en_d;
            ctl_q     <= ctl_d;
            emin_q    <= emin_d;
            emax_q    <= emax_d;
            tmin_q    <= tmin_d;
            tmax_q    <= tmax_d;
            per_q     <= per_d;
            dead_q    <= dead_d;
        end
    end
    assign hreadyout = !rd_wait_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // ****************************************************
    // Clamp, linear map and duty derivation
    // ****************************************************
    // Sign bit flipped so unsigned compares order signed values
    // R9 R10 signed order kept
    logic [DW-1:0] u_ctl, u_min, u_max, espan, tspan, diff_q, diff_d;
    logic [NUM_W-1:0] quot;
    logic          div_done, div_start;
    logic [DW:0]   on_sum;
    assign u_ctl = ctl_q ^ SIGN_FLIP;
    assign u_min = emin_q ^ SIGN_FLIP;
    assign u_max = emax_q ^ SIGN_FLIP;
    assign espan = sat_sub(u_max, u_min);
    assign tspan = sat_sub(tmax_q, tmin_q);
    assign div_start = (st_q == S_MUL) && (espan != '0);
    assign on_sum = {1'b0, quot[DW-1:0]} + {1'b0, tmin_q};

    hbp_div u_div (
        .clk   (sys_clk),
        .rst_n (rst_s_q),
        .start (div_start),
        .num   (NUM_W'(diff_q) * NUM_W'(tspan)),
        .den   (espan),
        .busy  (),
        .done  (div_done),
        .quot  (quot)
    );

    always_comb begin
        st_d     = st_q;
        diff_d   = diff_q;
        chi_d    = chi_q;
        clo_d    = clo_q;
        on_d     = on_q;
        dah_p_d  = dah_p_q;
        dal_p_d  = dal_p_q;
        dbh_p_d  = dbh_p_q;
        dbl_p_d  = dbl_p_q;
        per_p_d  = per_p_q;
        dead_p_d = dead_p_q;
        // New controller word wins over the clear
        go_d     = wr_ctl ? 1'b1 : (go_q && st_q != S_IDLE);
        unique case (st_q)
            S_IDLE: if (go_q) begin
                // R11 saturate at limits
                chi_d  = u_ctl > u_max;
                clo_d  = u_ctl < u_min;
                diff_d = chi_d ? espan : (clo_d ? '0 : sat_sub(u_ctl, u_min));
                st_d   = S_MUL;
            end
            S_MUL: begin
                if (espan == '0) begin
                    on_d = tmin_q;
                    st_d = S_FIN;
                end else begin
                    st_d = S_DIV;
                end
            end
            S_DIV: if (div_done) begin
                // R13 scaled offset plus minimum; R12 ends map to limits
                on_d = on_sum[DW] ? '1 : on_sum[DW-1:0];
                st_d = S_FIN;
            end
            S_FIN: begin
                // R15 on-time kept inside the period
                if (on_q > per_q) begin
                    on_d = per_q;
                end
                // R6 high-switch conducts while low, so duty is period minus on
                dah_p_d  = sat_sub(per_q, (on_q > per_q) ? per_q : on_q);
                // R7 side A low loses a dead time at each edge
                dal_p_d  = sat_sub(dah_p_d, {dead_q[DW-2:0], 1'b0});
                // R8 side B complementary to side A
                dbh_p_d  = per_q - dah_p_d;
                dbl_p_d  = sat_sub(dbh_p_d, {dead_q[DW-2:0], 1'b0});
                per_p_d  = per_q;
                dead_p_d = dead_q;
                st_d     = S_IDLE;
            end
        endcase
        // R14 all four duties staged together
        pend_d = (st_q == S_FIN) ? 1'b1 : (wrap ? 1'b0 : pend_q);
    end

    always_ff @(posedge sys_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            st_q     <= S_IDLE;
            go_q     <= 1'b0;
            diff_q   <= '0;
            chi_q    <= 1'b0;
            clo_q    <= 1'b0;
            on_q     <= '0;
            pend_q   <= 1'b0;
            dah_p_q  <= '0;
            dal_p_q  <= '0;
            dbh_p_q  <= '0;
            dbl_p_q  <= '0;
            per_p_q  <= RST_PERIOD;
            dead_p_q <= RST_DEAD;
        end else begin
            st_q     <= st_d;
            go_q     <= go_d;
            diff_q   <= diff_d;
            chi_q    <= chi_d;
            clo_q    <= clo_d;
            on_q     <= on_d;
            pend_q   <= pend_d;
            dah_p_q  <= dah_p_d;
            dal_p_q  <= dal_p_d;
            dbh_p_q  <= dbh_p_d;
            dbl_p_q  <= dbl_p_d;
            per_p_q  <= per_p_d;
            dead_p_q <= dead_p_d;
        end
    end

    // ****************************************************
    // PWM counter and drives
    // ****************************************************
    logic ah_d, al_d, bh_d, bl_d, ah_q, al_q, bh_q, bl_q;
    logic [DW:0] a_lo_end, b_lo_beg, b_lo_end;
    // R1 single counter sets the common period
    assign wrap = (cnt_q >= per_a_q - 16'h0001) || (per_a_q == '0);

    always_comb begin
        cnt_d    = wrap ? '0 : cnt_q + 16'h0001;
        // R16 staged counts go live only at the boundary
        dah_d    = (wrap && pend_q) ? dah_p_q : dah_q;
        dal_d    = (wrap && pend_q) ? dal_p_q : dal_q;
        dbl_d    = (wrap && pend_q) ? dbl_p_q : dbl_q;
        per_a_d  = (wrap && pend_q) ? per_p_q : per_a_q;
        dead_a_d = (wrap && pend_q) ? dead_p_q : dead_a_q;
        a_lo_end = {1'b0, dead_a_q} + {1'b0, dal_q};
        b_lo_beg = {1'b0, dah_q} + {1'b0, dead_a_q};
        b_lo_end = b_lo_beg + {1'b0, dbl_q};
        // R4 each drive is high for its duty count
        ah_d = (cnt_q < dah_q);
        bh_d = !ah_d;
        // R2 R3 R5 low drives sit a dead time inside the opposite window
        al_d = ({1'b0, cnt_q} >= {1'b0, dead_a_q}) && ({1'b0, cnt_q} < a_lo_end);
        bl_d = ({1'b0, cnt_q} >= b_lo_beg) && ({1'b0, cnt_q} < b_lo_end);
        // Disabled: drives high side off (p-channel high), low side off
        if (!en_q) begin
            ah_d = 1'b1;
            bh_d = 1'b1;
            al_d = 1'b0;
            bl_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            cnt_q    <= '0;
            dah_q    <= '0;
            dal_q    <= '0;
            dbl_q    <= '0;
            per_a_q  <= RST_PERIOD;
            dead_a_q <= RST_DEAD;
            ah_q     <= 1'b1;
            bh_q     <= 1'b1;
            al_q     <= 1'b0;
            bl_q     <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            dah_q    <= dah_d;
            dal_q    <= dal_d;
            dbl_q    <= dbl_d;
            per_a_q  <= per_a_d;
            dead_a_q <= dead_a_d;
            ah_q     <= ah_d;
            bh_q     <= bh_d;
            al_q     <= al_d;
            bl_q     <= bl_d;
        end
    end
    assign side_a_high_drive = ah_q;
    assign side_a_low_drive  = al_q;
    assign side_b_high_drive = bh_q;
    assign side_b_low_drive  = bl_q;

    // ****************************************************
    // Assertions
    // ****************************************************
    sequence s_fin;
        st_q == S_FIN;
    endsequence
    property p_no_shoot_a;
        @(posedge sys_clk) disable iff (!rst_s_q) !(!ah_q && al_q);
    endproperty
    a_no_shoot_a: assert property (p_no_shoot_a) else $error("Side A overlap"); // R2
    property p_no_shoot_b;
        @(posedge sys_clk) disable iff (!rst_s_q) !(!bh_q && bl_q);
    endproperty
    a_no_shoot_b: assert property (p_no_shoot_b) else $error("Side B overlap"); // R2
    property p_dead_a;
        @(posedge sys_clk) disable iff (!rst_s_q)
            $fell(al_q) && dead_a_q != '0 |-> ah_q;
    endproperty
    a_dead_a: assert property (p_dead_a) else $error("No dead time on A"); // R3
    property p_period;
        @(posedge sys_clk) disable iff (!rst_s_q) per_a_q != '0 |-> cnt_q < per_a_q;
    endproperty
    a_period: assert property (p_period) else $error("Counter past period"); // R1
    property p_load_edge;
        @(posedge sys_clk) disable iff (!rst_s_q) $changed(dah_q) |-> $past(wrap);
    endproperty
    a_load_edge: assert property (p_load_edge) else $error("Duty changed mid period"); // R16
    property p_clamp;
        @(posedge sys_clk) disable iff (!rst_s_q)
            st_q == S_MUL |-> diff_q <= espan;
    endproperty
    a_clamp: assert property (p_clamp) else $error("Clamp exceeded span"); // R11
    property p_b_compl;
        @(posedge sys_clk) disable iff (!rst_s_q)
            s_fin |=> {1'b0, dbh_p_q} + {1'b0, dah_p_q} == {1'b0, per_p_q};
    endproperty
    a_b_compl: assert property (p_b_compl) else $error("Side B not complementary"); // R8
    property p_a_low;
        @(posedge sys_clk) disable iff (!rst_s_q)
            s_fin |=> dal_p_q == '0 || dal_p_q + {dead_p_q[DW-2:0], 1'b0} == dah_p_q;
    endproperty
    a_a_low: assert property (p_a_low) else $error("Side A low duty wrong"); // R7
    property p_on_range;
        @(posedge sys_clk) disable iff (!rst_s_q)
            s_fin ##0 (tmax_q <= per_q && tmin_q <= tmax_q) |-> on_q >= tmin_q && on_q <= tmax_q;
    endproperty
    a_on_range: assert property (p_on_range) else $error("On-time outside limits"); // R12
endmodule // hbp_duty_mapper

// >>> src/hbp_pkg.sv
// Constants and types for the H-bridge PWM duty mapper
package hbp_pkg;
    localparam int unsigned DW = 16;
    localparam int unsigned NUM_W = 32;
    // ****************************************************
    // Register byte offsets
    // ****************************************************
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CTL_OUT = 8'h04;
    localparam logic [7:0] OFF_E_MIN   = 8'h08;
    localparam logic [7:0] OFF_E_MAX   = 8'h0C;
    localparam logic [7:0] OFF_T_MIN   = 8'h10;
    localparam logic [7:0] OFF_T_MAX   = 8'h14;
    localparam logic [7:0] OFF_PERIOD  = 8'h18;
    localparam logic [7:0] OFF_DEAD    = 8'h1C;
    localparam logic [7:0] OFF_STATUS  = 8'h20;
    localparam logic [7:0] OFF_DUTY_AH = 8'h24;
    localparam logic [7:0] OFF_ON_TIME = 8'h28;
    // ****************************************************
    // Fields and reset values
    // ****************************************************
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_PEND_BIT = 1;
    localparam int unsigned ST_CHI_BIT  = 2;
    localparam int unsigned ST_CLO_BIT  = 3;
    localparam logic [DW-1:0] RST_CTL_OUT = 16'h0000;
    localparam logic [DW-1:0] RST_E_MIN   = 16'hC000;
    localparam logic [DW-1:0] RST_E_MAX   = 16'h3FFF;
    localparam logic [DW-1:0] RST_T_MIN   = 16'h0064;
    localparam logic [DW-1:0] RST_T_MAX   = 16'h0384;
    localparam logic [DW-1:0] RST_PERIOD  = 16'h03E8;
    localparam logic [DW-1:0] RST_DEAD    = 16'h000A;
    localparam logic [DW-1:0] SIGN_FLIP   = 16'h8000;
    localparam logic [1:0]    HTRANS_NSEQ = 2'h2;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_MUL  = 4'b0010,
        S_DIV  = 4'b0100,
        S_FIN  = 4'b1000
    } hbp_state_e;
endpackage

// >>> verification/hbp_duty_mapper_tb_top.sv
// Self-checking bench for the H-bridge PWM duty mapper
`timescale 1ns/100ps
module hbp_duty_mapper_tb_top;
    import hbp_pkg::*;
    localparam int P = 100;
    localparam int DT = 5;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        side_a_high_drive;
    logic        side_a_low_drive;
    logic        side_b_high_drive;
    logic        side_b_low_drive;
    logic        clr = 1'b0;
    logic [15:0] c_ah;
    logic [15:0] c_al;
    logic [15:0] c_bh;
    logic [15:0] c_bl;
    logic        fault;
    logic [31:0] rd;
    int          fails = 0;
    int          tests_run = 0;
    logic [7:0]  ra [9] = '{OFF_CTRL, OFF_CTL_OUT, OFF_E_MIN, OFF_E_MAX, OFF_T_MIN,
                            OFF_T_MAX, OFF_PERIOD, OFF_DEAD, 8'h30};
    logic [15:0] rv [9] = '{16'h0000, RST_CTL_OUT, RST_E_MIN, RST_E_MAX, RST_T_MIN,
                            RST_T_MAX, RST_PERIOD, RST_DEAD, 16'h0000};
    logic [7:0]  ca [7] = '{OFF_PERIOD, OFF_DEAD, OFF_E_MIN, OFF_E_MAX, OFF_T_MIN,
                            OFF_T_MAX, OFF_CTRL};
    logic [15:0] cv [7] = '{16'h0064, 16'h0005, 16'hFF9C, 16'h0064, 16'h0014,
                            16'h0050, 16'h0001};
    logic [15:0] xs [5] = '{16'hFF38, 16'hFF9C, 16'h0000, 16'h0032, 16'h012C};

    always #2.5 sys_clk = ~sys_clk;

    hbp_duty_mapper hbp_duty_mapper_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .side_a_high_drive(side_a_high_drive), .side_a_low_drive(side_a_low_drive),
        .side_b_high_drive(side_b_high_drive), .side_b_low_drive(side_b_low_drive));

    hbp_gate_model hbp_gate_model_inst (
        .sys_clk(sys_clk), .clr(clr), .side_a_high_drive(side_a_high_drive),
        .side_a_low_drive(side_a_low_drive), .side_b_high_drive(side_b_high_drive),
        .side_b_low_drive(side_b_low_drive), .cnt_ah(c_ah), .cnt_al(c_al),
        .cnt_bh(c_bh), .cnt_bl(c_bl), .fault(fault));

    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
            fails++;
        end
    endtask

    // Hang guard: a stuck bus ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            $display("wrong value at %0t ns: bus never ready", $time);
            fails++;
            complete_run();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NSEQ;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    // Poll until compute done and new duties loaded
    // Bound covers a whole reset-length period before the first load
    task automatic settle();
        int n;
        n = 0;
        do begin
            ahb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (rd[1:0] !== 2'b00 && n < 1000);
        if (rd[1:0] !== 2'b00) begin
            $display("wrong value at %0t ns: load never finished", $time);
            fails++;
            complete_run();
        end
    endtask

    // Window of exactly one period, so phase does not matter
    task automatic measure();
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (P) @(posedge sys_clk);
        #1;
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        int x;
        int on;
        int dah;
        int dbh;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({28'h0, side_a_high_drive, side_a_low_drive, side_b_high_drive,
             side_b_low_drive}, 32'hA, "drives not off while disabled");
        for (int i = 0; i < 9; i++) begin
            ahb(1'b0, ra[i], 32'h0);
            chk(rd, {16'h0, rv[i]}, "register reset value");
        end
        $display("test reset values done");
        for (int i = 0; i < 7; i++) begin
            ahb(1'b1, ca[i], {16'h0, cv[i]});
        end
        for (int i = 0; i < 5; i++) begin
            // Last case: second write lands during compute of the first
            if (i == 4) begin
                ahb(1'b1, OFF_CTL_OUT, 32'h0000_FF38);
            end
            ahb(1'b1, OFF_CTL_OUT, {16'h0, xs[i]});
            settle();
            x = $signed(xs[i]);
            on = (((x < -100) ? -100 : ((x > 100) ? 100 : x)) + 100) * 60 / 200 + 20;
            dah = P - on;
            dbh = P - dah;
            chk({30'h0, rd[3:2]}, {30'h0, x < -100, x > 100}, "clamp flags");
            ahb(1'b0, OFF_ON_TIME, 32'h0);
            chk(rd, on, "on-time");
            ahb(1'b0, OFF_DUTY_AH, 32'h0);
            chk(rd, dah, "side A high duty");
            measure();
            chk({16'h0, c_ah}, dah, "side A high drive time");
            chk({16'h0, c_al}, dah - 2 * DT, "side A low drive time");
            chk({16'h0, c_bh}, dbh, "side B high drive time");
            chk({16'h0, c_bl}, dbh - 2 * DT, "side B low drive time");
            @(posedge sys_clk);
            $display("test mapping case %0d done", i);
        end
        chk({31'h0, fault}, 32'h0, "overlap or missing dead interval");
        complete_run();
    end
endmodule // hbp_duty_mapper_tb_top

// >>> verification/hbp_gate_model.sv
// Gate-side model of the four bridge switches, with drive-high counters
`timescale 1ns/100ps
module hbp_gate_model (
    input  wire logic        sys_clk,
    input  wire logic        clr,
    input  wire logic        side_a_high_drive,
    input  wire logic        side_a_low_drive,
    input  wire logic        side_b_high_drive,
    input  wire logic        side_b_low_drive,
    output logic [15:0]      cnt_ah,
    output logic [15:0]      cnt_al,
    output logic [15:0]      cnt_bh,
    output logic [15:0]      cnt_bl,
    output logic             fault
);
    logic a_hi_on;
    logic a_lo_on;
    logic b_hi_on;
    logic b_lo_on;
    logic pa_hi = 1'b0;
    logic pa_lo = 1'b0;
    logic pb_hi = 1'b0;
    logic pb_lo = 1'b0;
    logic bad;
    initial fault = 1'b0;
    assign a_hi_on = !side_a_high_drive;
    assign a_lo_on = side_a_low_drive;
    assign b_hi_on = !side_b_high_drive;
    assign b_lo_on = side_b_low_drive;
    // overlap, or handover with no idle cycle
    assign bad = (a_hi_on & a_lo_on) | (pa_hi & a_lo_on) | (pa_lo & a_hi_on)
               | (b_hi_on & b_lo_on) | (pb_hi & b_lo_on) | (pb_lo & b_hi_on);
    always @(posedge sys_clk) begin
        cnt_ah <= clr ? 16'h0000 : cnt_ah + {15'h0, side_a_high_drive};
        cnt_al <= clr ? 16'h0000 : cnt_al + {15'h0, side_a_low_drive};
        cnt_bh <= clr ? 16'h0000 : cnt_bh + {15'h0, side_b_high_drive};
        cnt_bl <= clr ? 16'h0000 : cnt_bl + {15'h0, side_b_low_drive};
        pa_hi <= a_hi_on;
        pa_lo <= a_lo_on;
        pb_hi <= b_hi_on;
        pb_lo <= b_lo_on;
        if (bad === 1'b1) begin
            fault <= 1'b1;
        end
    end
endmodule // hbp_gate_model
